/* hw/gcuf_defines.vh */
/*
 * Register offsets, field positions, reset values and bus codes of the
 * general configuration block.
 * Assumes it is included by the design files by its bare name.
 */
`ifndef GCUF_DEFINES_VH
`define GCUF_DEFINES_VH

// ----------------------------------------------------------------------
// Register map (byte addresses, 12-bit)
// ----------------------------------------------------------------------
`define GCUF_ADDR_W 12
`define GCUF_CONF_ADDR 12'h000
`define GCUF_READBACK_IDX 10'h036
`define GCUF_STATUS_ADDR 12'h100
`define GCUF_MASK_ADDR 12'h104

// ----------------------------------------------------------------------
// Reset values and event width
// ----------------------------------------------------------------------
`define GCUF_CONF_RESET 32'h00006020
`define GCUF_EVENT_W 3

// ----------------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------------
`define GCUF_STEP_SRC_HI 7
`define GCUF_STEP_SRC_LO 6
`define GCUF_ENC_TYPE_HI 11
`define GCUF_ENC_TYPE_LO 10
`define GCUF_DIFF_DISABLE 12
`define GCUF_INTR_POL 15
`define GCUF_ARRIVAL_INV 16
`define GCUF_CLK_GATE_EN 17
`define GCUF_CLK_GATE_STDBY 18
`define GCUF_PWM_SELECT 23
`define GCUF_EXIT_RESTART 26
`define GCUF_READBACK_SEL 27
`define GCUF_TABLE_REVERSE 28
`define GCUF_PULL_DRIVE 29
`define GCUF_INTR_WIRED_AND 30
`define GCUF_ARRIVAL_WIRED_AND 31

// ----------------------------------------------------------------------
// Encoder type codes
// ----------------------------------------------------------------------
`define GCUF_ENC_INCREMENTAL 2'h0
`define GCUF_ENC_SSI 2'h1
`define GCUF_ENC_RESERVED 2'h2
`define GCUF_ENC_SPI 2'h3

// ----------------------------------------------------------------------
// Status bits and bus responses
// ----------------------------------------------------------------------
`define GCUF_EV_ARRIVAL 0
`define GCUF_EV_EXIT 1
`define GCUF_EV_BAD_ENC 2
`define GCUF_RESP_OKAY 2'h0
`define GCUF_RESP_SLVERR 2'h2

`endif

/* hw/gcuf_pin_drive.v */
/*
 * Output stage of one flag pin: strong drive, or gated pull drive that
 * acts as wired-OR or wired-AND.
 * Assumes the board resolves the pin from value and enable.
 */
`timescale 1ns/1ps
`default_nettype none

module gcuf_pin_drive (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Control
	input wire level_in,
	input wire pull_mode_in,
	input wire wired_and_in,
	// Pin
	output reg pin_out,
	output reg pin_oe_out
);

	// Strong mode drives both levels; wired-OR drives only a one and
	// wired-AND only a zero, leaving the other level to the pull.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_out <= 1'b0;
			pin_oe_out <= 1'b0;
		end else if (!pull_mode_in) begin
			pin_out <= level_in;
			pin_oe_out <= 1'b1;
		end else if (wired_and_in) begin
			pin_out <= 1'b0;
			pin_oe_out <= ~level_in;
		end else begin
			pin_out <= 1'b1;
			pin_oe_out <= level_in;
		end
	end

endmodule

`default_nettype wire

/* hw/gcuf_exit_restart.v */
/*
 * Detects the end of direct external step control and loads the motion
 * state with zero or with the start values.
 * Assumes start values are stable in the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module gcuf_exit_restart #(
	parameter W = 32
) (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Control
	input wire [1:0] step_source_in,
	input wire restart_in,
	input wire [W-1:0] start_velocity_in,
	input wire [W-1:0] start_acceleration_in,
	// Load
	output reg load_out,
	output reg [W-1:0] current_velocity_out,
	output reg [W-1:0] current_acceleration_out
);

	reg direct_prev;
	wire direct_now;

	// Any nonzero step source means steps come from the step inputs.
	assign direct_now = |step_source_in;

	// A falling edge of direct control issues one load pulse.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			direct_prev <= 1'b0;
			load_out <= 1'b0;
			current_velocity_out <= {W{1'b0}};
			current_acceleration_out <= {W{1'b0}};
		end else begin
			direct_prev <= direct_now;
			load_out <= direct_prev & ~direct_now;
			if (direct_prev && !direct_now) begin
				current_velocity_out <= restart_in ? start_velocity_in : {W{1'b0}};
				current_acceleration_out <= restart_in ? start_acceleration_in : {W{1'b0}};
			end
		end
	end

endmodule

`default_nettype wire

/* hw/gcuf_top.v */
/*
 * Upper fields of the general configuration word of a stepper motion
 * controller, with an AXI4-Lite register slave, event status and the
 * output steering that the fields control.
 * Assumes all inputs are synchronous to clk_in.
 */
// Design decision made here: the AXI4-Lite interface to the registers.
// Behaviour
// - Encoder type field selects incremental, SSI, SPI.
// - Differential inputs off; forced on SPI type.
// - Interrupt polarity bit sets active pin level.
// - Arrival polarity bit inverts target reached output.
// - Clock gating enable permits internal clock gating.
// - Standby gating bit permits gating in standby.
// - PWM select routes PWM phases onto step pins.
// - Leaving direct control zeroes or loads start values.
// - Readback select picks latch or revolution count.
// - Table reverse bit reverses microstep table direction.
// - Drive bit picks strong or gated pull outputs.
// - Interrupt pin wired-OR or wired-AND under pull.
// - Arrival pin wired-OR or wired-AND under pull.
// - Configuration word resets to its default, read/write.
// - Nonzero step source field means direct control.
`timescale 1ns/1ps
`default_nettype none
`include "gcuf_defines.vh"

module gcuf_top #(
	parameter DATA_W = 32
) (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// AXI4-Lite write address and data
	input wire [`GCUF_ADDR_W-1:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output reg s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output reg s_axi_wready_out,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	// AXI4-Lite read
	input wire [`GCUF_ADDR_W-1:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output reg s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	// Core status inputs
	input wire interrupt_request_in,
	input wire target_reached_in,
	input wire standby_in,
	input wire [DATA_W-1:0] latch_position_in,
	input wire [DATA_W-1:0] revolution_count_in,
	input wire [DATA_W-1:0] start_velocity_in,
	input wire [DATA_W-1:0] start_acceleration_in,
	// Step sources
	input wire step_gen_in,
	input wire direction_gen_in,
	input wire pwm_phase_a_in,
	input wire pwm_phase_b_in,
	// Step pins
	output reg step_out,
	output reg direction_out,
	// Flag pins
	output wire interrupt_pin_out,
	output wire interrupt_pin_oe_out,
	output wire arrival_pin_out,
	output wire arrival_pin_oe_out,
	// Encoder and clock control
	output reg [1:0] encoder_type_out,
	output reg diff_input_enable_out,
	output reg clock_gate_permit_out,
	output reg table_reverse_out,
	// Motion state load on leaving direct control
	output wire motion_load_out,
	output wire [DATA_W-1:0] current_velocity_out,
	output wire [DATA_W-1:0] current_acceleration_out,
	// Event interrupt
	output reg irq_out
);

	// ------------------------------------------------------------------
	// Registers and wires
	// ------------------------------------------------------------------
	reg [31:0] general_configuration;
	reg [`GCUF_EVENT_W-1:0] event_status;
	reg [`GCUF_EVENT_W-1:0] event_mask;
	reg [`GCUF_ADDR_W-1:0] wr_addr;
	reg [31:0] wr_data;
	reg [3:0] wr_strb;
	reg aw_held;
	reg w_held;
	reg arrival_prev;
	reg [31:0] next_conf;
	reg [31:0] rd_value;
	reg rd_hit;
	reg wr_hit;
	wire do_write;
	wire do_read;
	wire status_read;
	wire [`GCUF_ADDR_W-1:0] readback_addr;
	wire [`GCUF_EVENT_W-1:0] events;
	wire arrival_event;
	wire exit_event;
	wire bad_enc_event;
	wire intr_level;
	wire arrival_level;
	integer i;

	// Readback register sits at four times its index.
	assign readback_addr = {`GCUF_READBACK_IDX, 2'b00};

	// A write is performed once address and data are both held.
	assign do_write = aw_held & w_held & ~s_axi_bvalid_out;
	assign do_read = s_axi_arvalid_in & s_axi_arready_out;
	assign status_read = do_read & (s_axi_araddr_in == `GCUF_STATUS_ADDR);

	// ------------------------------------------------------------------
	// Configuration write merge
	// ------------------------------------------------------------------

	// Byte strobes select lanes; the SPI encoder type forces the
	// differential inputs off in the stored word.
	always @* begin
		next_conf = general_configuration;
		for (i = 0; i < 4; i = i + 1) begin
			if (wr_strb[i]) begin
				next_conf[i*8 +: 8] = wr_data[i*8 +: 8];
			end
		end
		if (next_conf[`GCUF_ENC_TYPE_HI:`GCUF_ENC_TYPE_LO] == `GCUF_ENC_SPI) begin
			next_conf[`GCUF_DIFF_DISABLE] = 1'b1;
		end
	end

	// Write address decode.
	always @* begin
		if (wr_addr == `GCUF_CONF_ADDR) begin
			wr_hit = 1'b1;
		end else if (wr_addr == `GCUF_MASK_ADDR) begin
			wr_hit = 1'b1;
		end else if (wr_addr == `GCUF_STATUS_ADDR) begin
			wr_hit = 1'b1;
		end else if (wr_addr == readback_addr) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------

	// Address and data are taken independently and held until the write.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= {`GCUF_ADDR_W{1'b0}};
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `GCUF_RESP_OKAY;
		end else begin
			s_axi_awready_out <= ~aw_held & ~s_axi_awready_out & ~s_axi_bvalid_out;
			s_axi_wready_out <= ~w_held & ~s_axi_wready_out & ~s_axi_bvalid_out;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held <= 1'b1;
				wr_addr <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held <= 1'b1;
				wr_data <= s_axi_wdata_in;
				wr_strb <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_hit ? `GCUF_RESP_OKAY : `GCUF_RESP_SLVERR;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// Configuration and mask storage; reserved bits are kept as written.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			general_configuration <= `GCUF_CONF_RESET;
			event_mask <= {`GCUF_EVENT_W{1'b0}};
		end else if (do_write) begin
			if (wr_addr == `GCUF_CONF_ADDR) begin
				general_configuration <= next_conf;
			end else if (wr_addr == `GCUF_MASK_ADDR) begin
				if (wr_strb[0]) begin
					event_mask <= wr_data[`GCUF_EVENT_W-1:0];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------

	// Read decode; the readback word follows the select bit.
	always @* begin
		rd_hit = 1'b1;
		rd_value = 32'h00000000;
		if (s_axi_araddr_in == `GCUF_CONF_ADDR) begin
			rd_value = general_configuration;
		end else if (s_axi_araddr_in == `GCUF_STATUS_ADDR) begin
			rd_value[`GCUF_EVENT_W-1:0] = event_status;
		end else if (s_axi_araddr_in == `GCUF_MASK_ADDR) begin
			rd_value[`GCUF_EVENT_W-1:0] = event_mask;
		end else if (s_axi_araddr_in == readback_addr) begin
			if (general_configuration[`GCUF_READBACK_SEL]) begin
				rd_value = revolution_count_in;
			end else begin
				rd_value = latch_position_in;
			end
		end else begin
			rd_hit = 1'b0;
		end
	end

	// One read at a time; data is captured when the address is taken.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= `GCUF_RESP_OKAY;
		end else begin
			s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out;
			if (do_read) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= rd_value;
				s_axi_rresp_out <= rd_hit ? `GCUF_RESP_OKAY : `GCUF_RESP_SLVERR;
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Events and status
	// ------------------------------------------------------------------

	// Arrival is a rising edge of target reached; a reserved encoder code
	// written by software is flagged because it must not be used.
	assign arrival_event = target_reached_in & ~arrival_prev;
	assign bad_enc_event = do_write & (wr_addr == `GCUF_CONF_ADDR) &
		(next_conf[`GCUF_ENC_TYPE_HI:`GCUF_ENC_TYPE_LO] == `GCUF_ENC_RESERVED);
	assign exit_event = motion_load_out;
	assign events = {bad_enc_event, exit_event, arrival_event};

	// Sticky status: a read clears it, but a new event in that cycle stays.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			arrival_prev <= 1'b0;
			event_status <= {`GCUF_EVENT_W{1'b0}};
			irq_out <= 1'b0;
		end else begin
			arrival_prev <= target_reached_in;
			if (status_read) begin
				event_status <= events;
			end else begin
				event_status <= event_status | events;
			end
			irq_out <= |(event_status & event_mask);
		end
	end

	// ------------------------------------------------------------------
	// Steering outputs
	// ------------------------------------------------------------------

	// Step pins carry step and direction or the two PWM phases.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			step_out <= 1'b0;
			direction_out <= 1'b0;
		end else if (general_configuration[`GCUF_PWM_SELECT]) begin
			step_out <= pwm_phase_a_in;
			direction_out <= pwm_phase_b_in;
		end else begin
			step_out <= step_gen_in;
			direction_out <= direction_gen_in;
		end
	end

	// Encoder selection, clock gating permission and table direction.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			encoder_type_out <= `GCUF_ENC_INCREMENTAL;
			diff_input_enable_out <= 1'b0;
			clock_gate_permit_out <= 1'b0;
			table_reverse_out <= 1'b0;
		end else begin
			encoder_type_out <= general_configuration[`GCUF_ENC_TYPE_HI:`GCUF_ENC_TYPE_LO];
			diff_input_enable_out <= ~general_configuration[`GCUF_DIFF_DISABLE];
			clock_gate_permit_out <= general_configuration[`GCUF_CLK_GATE_EN] &
				(~standby_in | general_configuration[`GCUF_CLK_GATE_STDBY]);
			table_reverse_out <= general_configuration[`GCUF_TABLE_REVERSE];
		end
	end

	// Pin levels: polarity for interrupt, inversion for arrival.
	assign intr_level = interrupt_request_in ~^ general_configuration[`GCUF_INTR_POL];
	assign arrival_level = target_reached_in ^ general_configuration[`GCUF_ARRIVAL_INV];

	// Interrupt pin stage.
	gcuf_pin_drive u_intr_pin (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.level_in(intr_level),
		.pull_mode_in(general_configuration[`GCUF_PULL_DRIVE]),
		.wired_and_in(general_configuration[`GCUF_INTR_WIRED_AND]),
		.pin_out(interrupt_pin_out),
		.pin_oe_out(interrupt_pin_oe_out)
	);

	// Arrival pin stage.
	gcuf_pin_drive u_arrival_pin (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.level_in(arrival_level),
		.pull_mode_in(general_configuration[`GCUF_PULL_DRIVE]),
		.wired_and_in(general_configuration[`GCUF_ARRIVAL_WIRED_AND]),
		.pin_out(arrival_pin_out),
		.pin_oe_out(arrival_pin_oe_out)
	);

	// Leaving direct step control reloads velocity and acceleration.
	gcuf_exit_restart #(
		.W(DATA_W)
	) u_exit (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.step_source_in(general_configuration[`GCUF_STEP_SRC_HI:`GCUF_STEP_SRC_LO]),
		.restart_in(general_configuration[`GCUF_EXIT_RESTART]),
		.start_velocity_in(start_velocity_in),
		.start_acceleration_in(start_acceleration_in),
		.load_out(motion_load_out),
		.current_velocity_out(current_velocity_out),
		.current_acceleration_out(current_acceleration_out)
	);

endmodule

`default_nettype wire

/* tb/gcuf_host_model.sv */
/*
 * Host software model: an AXI4-Lite master with one word write and one word read task.
 * Assumes the slave answers each request in its own time.
 */
`timescale 1ns/1ps
`default_nettype none

module gcuf_host_model (
	// Clock
	input wire logic clk_in,
	// Write channels
	output logic [11:0] awaddr_out,
	output logic awvalid_out,
	input wire logic awready_in,
	output logic [31:0] wdata_out,
	output logic wvalid_out,
	input wire logic wready_in,
	input wire logic [1:0] bresp_in,
	input wire logic bvalid_in,
	output logic bready_out,
	// Read channels
	output logic [11:0] araddr_out,
	output logic arvalid_out,
	input wire logic arready_in,
	input wire logic [31:0] rdata_in,
	input wire logic [1:0] rresp_in,
	input wire logic rvalid_in,
	output logic rready_out
);
	// Reserved configuration bits that software always writes as zero.
	localparam logic [31:0] RSVD = 32'h03786000;

	// The bus is idle from time zero.
	initial begin
		{awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
		{araddr_out, arvalid_out, rready_out} = '0;
	end

	// One write: each channel is released at its own handshake.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		awaddr_out <= a;
		wdata_out <= (a == 12'h000) ? (d & ~RSVD) : d;
		awvalid_out <= 1'b1;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awvalid_out && awready_in)
				awvalid_out <= 1'b0;
			if (wvalid_out && wready_in)
				wvalid_out <= 1'b0;
		end while (!(bvalid_in && bready_out));
		r = bresp_in;
		bready_out <= 1'b0;
	endtask

	// One read: data and response are taken at the answer's edge.
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arvalid_out && arready_in)
				arvalid_out <= 1'b0;
		end while (!(rvalid_in && rready_out));
		d = rdata_in;
		r = rresp_in;
		rready_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* tb/gcuf_properties.sv */
/*
 * Checker for the configuration block: bus answers, encoder, step routing, motion load.
 * Assumes it is bound to gcuf_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module gcuf_properties #(
	parameter DATA_W = 32
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic step_gen_in,
	input wire logic pwm_phase_a_in,
	input wire logic step_out,
	input wire logic [1:0] encoder_type_out,
	input wire logic diff_input_enable_out,
	input wire logic motion_load_out,
	input wire logic [DATA_W-1:0] current_velocity_out,
	input wire logic [DATA_W-1:0] current_acceleration_out,
	input wire logic [DATA_W-1:0] start_velocity_in,
	input wire logic [DATA_W-1:0] start_acceleration_in,
	input wire logic irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Bus answers and their holding.
	write_answer_a: assert property (
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
		|-> ##[1:2] s_axi_bvalid_out) else $error("Write answer missing.");
	read_answer_a: assert property (
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("Read answer missing.");
	rvalid_hold_a: assert property (
		s_axi_rvalid_out |=> $stable(s_axi_rdata_out) && (s_axi_rvalid_out == !$past(s_axi_rready_in)))
		else $error("Read answer not held until taken or not withdrawn after.");
	ready_quiet_a: assert property (
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("Write offered while a response is pending.");
	// Field effects at the pins.
	enc_diff_a: assert property (
		encoder_type_out == 2'h3 |-> !diff_input_enable_out)
		else $error("Differential inputs left on for the serial encoder.");
	step_route_a: assert property (
		step_out == $past(step_gen_in) || step_out == $past(pwm_phase_a_in))
		else $error("Step pin from neither source.");
	load_pulse_a: assert property (
		motion_load_out |=> !motion_load_out) else $error("Motion load longer than a cycle.");
	load_values_a: assert property (
		motion_load_out |=> (current_velocity_out == 0 && current_acceleration_out == 0)
		|| (current_velocity_out == start_velocity_in
		&& current_acceleration_out == start_acceleration_in))
		else $error("Motion load with wrong values.");

	// Main scenarios reached.
	cover property (motion_load_out);
	cover property (encoder_type_out == 2'h3);
	cover property (irq_out);
endmodule

bind gcuf_top gcuf_properties #(.DATA_W(DATA_W)) i_props (.clk_in, .rst_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
	.s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
	.s_axi_rvalid_out, .s_axi_rready_in, .step_gen_in, .pwm_phase_a_in, .step_out,
	.encoder_type_out, .diff_input_enable_out, .motion_load_out, .current_velocity_out,
	.current_acceleration_out, .start_velocity_in, .start_acceleration_in, .irq_out);
`default_nettype wire

/* tb/gcuf_top_tb.sv */
/*
 * Self-checking testbench of the configuration block, with a host model as bus master.
 * Assumes the design files and the checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module gcuf_top_tb;
	logic clk_in, rst_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
	logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
	logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
	logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdv, lv, la;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp, encoder_type_out;
	logic interrupt_request_in, target_reached_in, standby_in, step_gen_in, direction_gen_in;
	logic [31:0] latch_position_in, revolution_count_in, start_velocity_in;
	logic [31:0] start_acceleration_in, current_velocity_out, current_acceleration_out;
	logic pwm_phase_a_in, pwm_phase_b_in, step_out, direction_out, interrupt_pin_out;
	logic interrupt_pin_oe_out, arrival_pin_out, arrival_pin_oe_out, diff_input_enable_out;
	logic clock_gate_permit_out, table_reverse_out, motion_load_out, irq_out;
	int bad_count, samples_checked, loads, n;

	// Design and host.
	gcuf_top i_dut (.clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
		.s_axi_wdata_in, .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in, .s_axi_wready_out,
		.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
		.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
		.s_axi_rvalid_out, .s_axi_rready_in, .interrupt_request_in, .target_reached_in,
		.standby_in, .latch_position_in, .revolution_count_in, .start_velocity_in,
		.start_acceleration_in, .step_gen_in, .direction_gen_in, .pwm_phase_a_in,
		.pwm_phase_b_in, .step_out, .direction_out, .interrupt_pin_out, .interrupt_pin_oe_out,
		.arrival_pin_out, .arrival_pin_oe_out, .encoder_type_out, .diff_input_enable_out,
		.clock_gate_permit_out, .table_reverse_out, .motion_load_out, .current_velocity_out,
		.current_acceleration_out, .irq_out);
	gcuf_host_model i_host (.clk_in, .awaddr_out(s_axi_awaddr_in),
		.awvalid_out(s_axi_awvalid_in), .awready_in(s_axi_awready_out),
		.wdata_out(s_axi_wdata_in), .wvalid_out(s_axi_wvalid_in), .wready_in(s_axi_wready_out),
		.bresp_in(s_axi_bresp_out), .bvalid_in(s_axi_bvalid_out), .bready_out(s_axi_bready_in),
		.araddr_out(s_axi_araddr_in), .arvalid_out(s_axi_arvalid_in),
		.arready_in(s_axi_arready_out), .rdata_in(s_axi_rdata_out), .rresp_in(s_axi_rresp_out),
		.rvalid_in(s_axi_rvalid_out), .rready_out(s_axi_rready_in));

	// Clock of 10 ns, and a log of every motion load.
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (motion_load_out === 1'b1) begin
			loads <= loads + 1;
			lv <= current_velocity_out;
			la <= current_acceleration_out;
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Pin value and enable for strong, wired-AND and wired-OR drive.
	function automatic logic [1:0] pin(input logic pull, input logic w, input logic lev);
		return !pull ? {lev, 1'b1} : (w ? {1'b0, !lev} : {1'b1, lev});
	endfunction

	task automatic cfg(input logic [31:0] d);
		i_host.wr(12'h000, d, rsp);
		repeat (3) @(posedge clk_in);
	endtask

	// Reset value and unmapped places.
	task automatic t_map();
		i_host.rd(12'h000, rdv, rsp);
		chk("conf reset", rdv, 32'h00006020);
		chk("diff enable", diff_input_enable_out, 1);
		i_host.wr(12'h204, 32'hffffffff, rsp);
		chk("unmapped wr", rsp, 2'h2);
		i_host.rd(12'h200, rdv, rsp);
		chk("unmapped rd", {rsp, rdv[29:0]}, 32'h80000000);
		i_host.rd(12'h000, rdv, rsp);
		chk("conf kept", rdv, 32'h00006020);
	endtask

	// Every encoder code, with the reserved code raising a masked event.
	task automatic t_encoder();
		i_host.rd(12'h100, rdv, rsp);
		i_host.wr(12'h104, 32'h4, rsp);
		for (int t = 0; t < 4; t++) begin
			cfg({20'h0, t[1:0], 10'h0});
			i_host.rd(12'h000, rdv, rsp);
			chk("enc type", encoder_type_out, t);
			chk("conf word", rdv, {19'h0, t == 3, t[1:0], 10'h0});
			chk("diff enable", diff_input_enable_out, t != 3);
			chk("irq", irq_out, t >= 2);
		end
		i_host.rd(12'h100, rdv, rsp);
		chk("status", rdv, 32'h4);
		repeat (2) @(posedge clk_in);
		chk("irq cleared", irq_out, 0);
		i_host.wr(12'h104, 32'h0, rsp);
		cfg(32'h00000800);
		chk("irq masked", irq_out, 0);
		i_host.rd(12'h100, rdv, rsp);
		chk("status", rdv, 32'h4);
	endtask

	// Polarity and drive style of both flag pins.
	task automatic t_pins();
		for (int i = 0; i < 128; i++) begin
			{interrupt_request_in, target_reached_in} <= i[1:0];
			cfg({i[6:4], 12'h0, i[3:2], 15'h0});
			chk("int pin", {interrupt_pin_out, interrupt_pin_oe_out},
				pin(i[4], i[5], i[2] ~^ i[1]));
			chk("arr pin", {arrival_pin_out, arrival_pin_oe_out},
				pin(i[4], i[6], i[0] ^ i[3]));
		end
	endtask

	// Step routing, table direction, clock gating and read-back choice.
	task automatic t_route();
		latch_position_in <= 32'h13572468;
		revolution_count_in <= 32'h0badcafe;
		pwm_phase_a_in <= 1'b1;
		direction_gen_in <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			standby_in <= i[0];
			cfg({3'h0, i[0], i[1], 3'h0, i[0], 4'h0, i[1], i[2], 17'h0});
			chk("step pins", {step_out, direction_out}, {i[0], !i[0]});
			chk("table rev", table_reverse_out, i[0]);
			chk("gate permit", clock_gate_permit_out, i[2] & (!i[0] | i[1]));
			i_host.rd(12'h0d8, rdv, rsp);
			chk("readback", rdv, i[1] ? 32'h0badcafe : 32'h13572468);
		end
	endtask

	// Leaving each external step mode, with and without restart values.
	task automatic t_exit();
		start_velocity_in <= 32'h00001111;
		start_acceleration_in <= 32'h00002222;
		for (int i = 2; i < 8; i++) begin
			n = loads;
			cfg({5'h0, i[0], 18'h0, i[2:1], 6'h0});
			chk("no load", loads, n);
			cfg({5'h0, i[0], 26'h0});
			for (int k = 0; k < 20 && loads == n; k++)
				@(posedge clk_in);
			chk("load count", loads, n + 1);
			chk("velocity", lv, i[0] ? 32'h00001111 : 32'h0);
			chk("accel", la, i[0] ? 32'h00002222 : 32'h0);
		end
		i_host.rd(12'h100, rdv, rsp);
		chk("exit event", rdv, 32'h3);
	endtask

	// Main sequence after 10 cycles of reset.
	initial begin
		rst_in = 1'b1;
		{interrupt_request_in, target_reached_in, standby_in, step_gen_in} = '0;
		{direction_gen_in, pwm_phase_a_in, pwm_phase_b_in} = '0;
		{latch_position_in, revolution_count_in} = '0;
		{start_velocity_in, start_acceleration_in} = '0;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		t_map();
		t_encoder();
		t_pins();
		t_route();
		t_exit();
		finish_test();
	end

	// A hang ends the run after 50000 cycles.
	initial begin
		#500000;
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
